// ---- src/predicate_compare_pkg.sv ----
// Purpose: constants and encodings for the predicate compare unit
// Assumes: 64-bit general registers, 64 predicate registers
// Notes: relation and type codes are local encodings from the decode stage
`default_nettype none
package predicate_compare_pkg;
	localparam int DATA_WIDTH = 64;
	localparam int PRED_INDEX_WIDTH = 6;
	localparam int IMM_WIDTH = 8;
	localparam int LATENCY_CYCLES = 1;

	// operand forms
	typedef enum logic [1:0] {
		FORM_REGISTER = 2'h0,
		FORM_SHORT_IMMEDIATE = 2'h1,
		FORM_ZERO_FIRST = 2'h2
	} operand_form_t;

	// implemented relations only; the rest are produced at encoding time
	typedef enum logic [2:0] {
		REL_EQ = 3'h0,
		REL_NE = 3'h1,
		REL_LT = 3'h2,
		REL_LE = 3'h3,
		REL_GT = 3'h4,
		REL_GE = 3'h5,
		REL_LTU = 3'h6
	} relation_t;

	// implemented compare types
	typedef enum logic [2:0] {
		CT_NORMAL = 3'h0,
		CT_UNC = 3'h1,
		CT_AND = 3'h2,
		CT_OR = 3'h3,
		CT_OR_ANDCM = 3'h4
	} compare_type_t;

	localparam logic RESET_VALID = 1'h0;
endpackage : predicate_compare_pkg
`default_nettype wire

// ---- src/predicate_compare_unit.sv ----
// Purpose: 64-bit integer compare writing two predicate destinations
// Assumes: operands and deferred-exception bits arrive with issue, same clock
// Notes: one-cycle latency; all outputs registered
//
// Overview of operation
// - first operand is register, sign-extended 8-bit immediate, or zero
// - zero-first form accepted only with parallel type and an inequality
// - same destinations fault when qualified, or always for unconditional type
// - deferred flag is third source OR second source in register form
// - relation evaluated over full 64-bit operands, one-bit result
// - normal and unconditional types implement only equal, signed-less, unsigned-less
// - complemented parallel types are negated relation with implemented types
// - parallel types only equal/not-equal, or signed against zero
// - parallel inequalities exist only with zero as first operand
// - and-type clears both when deferred flag or relation false
// - or-types write only when relation true and no deferred flag
// - unqualified: only unconditional type clears both; others do nothing
// - normal writes result and inverse; deferred flag writes zeros
// - unconditional clears both always, then acts as normal when qualified
`default_nettype none
module predicate_compare_unit
	import predicate_compare_pkg::*;
#(
	parameter int WIDTH = DATA_WIDTH
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input wire logic qualifying_predicate,
	input wire logic [1:0] operand_form,
	input wire logic [2:0] relation,
	input wire logic [2:0] compare_type,
	input wire logic [IMM_WIDTH-1:0] short_immediate,
	input wire logic [WIDTH-1:0] src2_value,
	input wire logic src2_deferred,
	input wire logic [WIDTH-1:0] src3_value,
	input wire logic src3_deferred,
	input wire logic [PRED_INDEX_WIDTH-1:0] dest1_index,
	input wire logic [PRED_INDEX_WIDTH-1:0] dest2_index,
	output logic dest1_write,
	output logic [PRED_INDEX_WIDTH-1:0] dest1_write_index,
	output logic dest1_write_value,
	output logic dest2_write,
	output logic [PRED_INDEX_WIDTH-1:0] dest2_write_index,
	output logic dest2_write_value,
	output logic illegal_operation_fault,
	output logic done
);
	logic [WIDTH-1:0] first_operand;
	logic deferred;
	logic rel_eq;
	logic rel_lt;
	logic rel_ltu;
	logic rel_result;
	logic is_parallel;
	logic is_inequality;
	logic encoding_legal;
	logic same_dest;
	logic fault_now;
	logic w1;
	logic w2;
	logic v1;
	logic v2;
	logic next_dest1_write;
	logic next_dest2_write;
	logic next_dest1_write_value;
	logic next_dest2_write_value;
	logic [PRED_INDEX_WIDTH-1:0] next_dest1_write_index;
	logic [PRED_INDEX_WIDTH-1:0] next_dest2_write_index;
	logic next_fault;
	logic next_done;
	logic is_equality;
	logic is_base_relation;
	logic code_known;
	logic form_legal;
	logic relation_holds;
	logic relation_fails;

	// first operand select from register, immediate or zero
	always_comb
	begin
		unique case (operand_form_t'(operand_form))
			FORM_REGISTER: first_operand = src2_value;
			FORM_SHORT_IMMEDIATE: first_operand = {{(WIDTH-IMM_WIDTH){short_immediate[IMM_WIDTH-1]}}, short_immediate};
			default: first_operand = '0;
		endcase
	end

	// combined deferred-exception flag; immediate and zero add none
	always_comb
	begin
		deferred = src3_deferred | ((operand_form == FORM_REGISTER) & src2_deferred);
	end

	// relation evaluation over the full operand width
	always_comb
	begin
		rel_eq = first_operand == src3_value;
		rel_lt = $signed(first_operand) < $signed(src3_value);
		rel_ltu = first_operand < src3_value;
		unique case (relation_t'(relation))
			REL_EQ: rel_result = rel_eq;
			REL_NE: rel_result = ~rel_eq;
			REL_LT: rel_result = rel_lt;
			REL_LE: rel_result = rel_lt | rel_eq;
			REL_GT: rel_result = ~(rel_lt | rel_eq);
			REL_GE: rel_result = ~rel_lt;
			REL_LTU: rel_result = rel_ltu;
			default: rel_result = 1'h0;
		endcase
	end

	// class of compare type and relation
	always_comb
	begin
		is_parallel = (compare_type == CT_AND) | (compare_type == CT_OR) | (compare_type == CT_OR_ANDCM);
		is_inequality = (relation == REL_LT) | (relation == REL_LE) | (relation == REL_GT) | (relation == REL_GE);
		is_equality = (relation == REL_EQ) | (relation == REL_NE);
		is_base_relation = (relation == REL_EQ) | (relation == REL_LT) | (relation == REL_LTU);
		code_known = (operand_form != 2'h3) & (compare_type <= CT_OR_ANDCM) & (relation != 3'h7);
	end

	// encoding legality check against implemented combinations
	always_comb
	begin
		form_legal = 1'h0;
		unique case (operand_form)
			FORM_ZERO_FIRST:
			begin
				// zero-first form only for parallel inequalities
				form_legal = is_parallel & is_inequality;
			end
			FORM_SHORT_IMMEDIATE:
			begin
				// no immediate inequality forms for parallel types
				if (is_parallel)
					form_legal = is_equality;
				else
					form_legal = is_base_relation;
			end
			FORM_REGISTER:
			begin
				// equality for parallel types, base relations otherwise
				if (is_parallel)
					form_legal = is_equality;
				else
					form_legal = is_base_relation;
			end
			default:
			begin
				// fourth form code is reserved
				form_legal = 1'h0;
			end
		endcase
		encoding_legal = form_legal & code_known;
	end

	// relation outcome once deferred sources are counted
	always_comb
	begin
		relation_holds = ~deferred & rel_result;
		relation_fails = deferred | ~rel_result;
	end

	// predicate update decision per compare type
	always_comb
	begin
		same_dest = dest1_index == dest2_index;
		w1 = 1'h0;
		w2 = 1'h0;
		v1 = 1'h0;
		v2 = 1'h0;
		fault_now = 1'h0;
		if (qualifying_predicate)
		begin
			fault_now = same_dest | ~encoding_legal;
			unique case (compare_type_t'(compare_type))
				CT_AND:
				begin
					w1 = relation_fails;
					w2 = relation_fails;
				end
				CT_OR:
				begin
					w1 = relation_holds;
					w2 = relation_holds;
					v1 = 1'h1;
					v2 = 1'h1;
				end
				CT_OR_ANDCM:
				begin
					w1 = relation_holds;
					w2 = relation_holds;
					v1 = 1'h1;
				end
				default:
				begin
					w1 = 1'h1;
					w2 = 1'h1;
					v1 = ~deferred & rel_result;
					v2 = ~deferred & ~rel_result;
				end
			endcase
		end
		else if (compare_type == CT_UNC)
		begin
			fault_now = same_dest;
			w1 = 1'h1;
			w2 = 1'h1;
		end
		// a faulting compare writes nothing
		if (fault_now || !issue_valid)
		begin
			w1 = 1'h0;
			w2 = 1'h0;
		end
	end

	// next values of the first destination port
	always_comb
	begin
		next_dest1_write = w1;
		next_dest1_write_value = v1;
		next_dest1_write_index = dest1_index;
	end

	// first destination port registers
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dest1_write <= RESET_VALID;
			dest1_write_value <= 1'h0;
			dest1_write_index <= '0;
		end
		else
		begin
			dest1_write <= next_dest1_write;
			dest1_write_value <= next_dest1_write_value;
			dest1_write_index <= next_dest1_write_index;
		end
	end

	// next values of the second destination port
	always_comb
	begin
		next_dest2_write = w2;
		next_dest2_write_value = v2;
		next_dest2_write_index = dest2_index;
	end

	// second destination port registers
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dest2_write <= RESET_VALID;
			dest2_write_value <= 1'h0;
			dest2_write_index <= '0;
		end
		else
		begin
			dest2_write <= next_dest2_write;
			dest2_write_value <= next_dest2_write_value;
			dest2_write_index <= next_dest2_write_index;
		end
	end

	// next value of the fault pulse
	always_comb
	begin
		next_fault = issue_valid & fault_now;
	end

	// fault pulse register
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			illegal_operation_fault <= RESET_VALID;
		end
		else
		begin
			illegal_operation_fault <= next_fault;
		end
	end

	// next value of the completion pulse, one per issue
	always_comb
	begin
		next_done = issue_valid;
	end

	// completion pulse register
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			done <= RESET_VALID;
		end
		else
		begin
			done <= next_done;
		end
	end
endmodule : predicate_compare_unit
`default_nettype wire

// ---- verification/predicate_compare_properties.sv ----
// Purpose: timing and value checks on compare unit outputs
// Assumes: answer one cycle after issue
// Notes: sees only the unit's ports
`default_nettype none
module predicate_compare_properties
	import predicate_compare_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input wire logic qualifying_predicate,
	input wire logic [2:0] compare_type,
	input wire logic [5:0] dest1_index,
	input wire logic [5:0] dest2_index,
	input wire logic dest1_write,
	input wire logic dest1_write_value,
	input wire logic dest2_write,
	input wire logic dest2_write_value,
	input wire logic illegal_operation_fault,
	input wire logic done
);
	timeunit 1ns / 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// short aliases
	wire logic same = dest1_index == dest2_index;
	wire logic nq = issue_valid && !qualifying_predicate;
	wire logic w1 = dest1_write;
	wire logic w2 = dest2_write;
	wire logic v1 = dest1_write_value;
	wire logic v2 = dest2_write_value;
	wire logic flt = illegal_operation_fault;
	// qualified issue to distinct destinations
	sequence q_issue;
		issue_valid && qualifying_predicate && !same;
	endsequence
	AST_DONE: assert property (issue_valid |=> done) else $error("done missing");
	AST_SAME_Q: assert property (issue_valid && qualifying_predicate && same |=> flt && !w1 && !w2)
		else $error("shared dest not refused");
	AST_SAME_UNC: assert property (issue_valid && compare_type == CT_UNC && same |=> flt)
		else $error("unc shared dest");
	AST_UNQ: assert property (nq && compare_type != CT_UNC |=> !w1 && !w2 && !flt)
		else $error("unqualified acted");
	AST_UNC_CLR: assert property (nq && compare_type == CT_UNC && !same |=> w1 && w2 && !v1 && !v2)
		else $error("unc did not clear");
	AST_NORMAL: assert property (q_issue ##0 compare_type == CT_NORMAL |=> flt || w1 && w2 && !(v1 && v2))
		else $error("normal write wrong");
	AST_AND: assert property (q_issue ##0 compare_type == CT_AND |=> flt || w1 == w2 && !(w1 && (v1 || v2)))
		else $error("and write wrong");
	AST_OR: assert property (q_issue ##0 compare_type == CT_OR |=> flt || w1 == w2 && (!w1 || v1 && v2))
		else $error("or write wrong");
	AST_ANDCM: assert property (q_issue ##0 compare_type == CT_OR_ANDCM |=> flt || w1 == w2 && (!w1 || v1 && !v2))
		else $error("or-andcm write wrong");
	AST_IDLE: assert property (!issue_valid |=> !done && !w1 && !w2 && !flt)
		else $error("output without issue");
endmodule : predicate_compare_properties
bind predicate_compare_unit predicate_compare_properties checker_i (.*);
`default_nettype wire

// ---- verification/predicate_file_model.sv ----
// Purpose: predicate register file behind the compare unit
// Assumes: both writes land on one edge
// Notes: flat state, cleared by reset
`default_nettype none
module predicate_file_model
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic dest1_write,
	input wire logic [5:0] dest1_write_index,
	input wire logic dest1_write_value,
	input wire logic dest2_write,
	input wire logic [5:0] dest2_write_index,
	input wire logic dest2_write_value,
	output logic [63:0] preds
);
	timeunit 1ns / 1ps;
	// apply both destination writes
	always @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			preds <= 64'h0;
		else
		begin
			if (dest1_write)
				preds[dest1_write_index] <= dest1_write_value;
			if (dest2_write)
				preds[dest2_write_index] <= dest2_write_value;
		end
endmodule : predicate_file_model
`default_nettype wire

// ---- verification/tb.sv ----
// Purpose: table-driven bench for the compare unit
// Assumes: answer one cycle after issue
// Notes: destinations 1 and 2 unless shared
`default_nettype none
`define chk(g, e) begin checked++; if ((g) !== (e)) \
	begin err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
	import predicate_compare_pkg::*;
;
	timeunit 1ns / 1ps;
	// qp, form, relation, type, imm, src2, flag, src3, flag, {fault, w1, v1, w2, v2}
	typedef struct packed {logic qp; logic [1:0] f; logic [2:0] r, t; logic [7:0] imm;
		logic [63:0] a; logic ad; logic [63:0] b; logic bd; logic [4:0] e;} row_t;
	localparam logic [63:0] m1 = 64'hFFFFFFFFFFFFFFFF;
	logic core_clk, rst_n, issue_valid, qualifying_predicate, src2_deferred, src3_deferred;
	logic [1:0] operand_form;
	logic [2:0] relation, compare_type;
	logic [7:0] short_immediate;
	logic [63:0] src2_value, src3_value, preds;
	logic [5:0] dest1_index, dest2_index, dest1_write_index, dest2_write_index;
	logic dest1_write, dest1_write_value, dest2_write, dest2_write_value, illegal_operation_fault, done;
	wire logic [5:0] outs = {done, illegal_operation_fault, dest1_write, dest1_write & dest1_write_value,
		dest2_write, dest2_write & dest2_write_value};
	int err_count = 0;
	int checked = 0;
	row_t rows [20] = '{
		'{1,0,0,0,0,5,0,5,0,5'h0E}, '{1,0,2,0,0,m1,0,1,0,5'h0E},
		'{1,0,6,1,0,m1,0,1,0,5'h0B}, '{1,0,1,0,0,5,0,6,0,5'h10},
		'{1,1,0,0,8'hFF,0,0,m1,0,5'h0E}, '{1,0,0,0,0,5,1,5,0,5'h0A},
		'{1,1,0,1,8'hFF,0,1,m1,0,5'h0E}, '{1,0,0,2,0,5,0,6,0,5'h0A},
		'{1,0,0,2,0,5,0,5,0,5'h00}, '{1,0,1,3,0,5,0,6,0,5'h0F},
		'{1,0,0,3,0,5,0,5,1,5'h00}, '{1,0,0,4,0,5,0,5,0,5'h0E},
		'{1,2,4,2,0,0,0,5,0,5'h0A}, '{1,2,5,3,0,0,0,0,0,5'h0F},
		'{1,2,2,0,0,0,0,5,0,5'h10}, '{1,2,6,2,0,0,0,5,0,5'h10},
		'{1,1,2,0,8'h7F,0,0,128,0,5'h0E}, '{1,1,3,0,8'h04,0,0,5,0,5'h10},
		'{0,0,0,1,0,5,0,5,0,5'h0A}, '{0,0,0,2,0,5,0,6,0,5'h00}};
	predicate_compare_unit DUT (.*);
	predicate_file_model partner (.*);
	// core clock
	initial
	begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end
	// verdict and end of run
	task print_verdict;
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// one issue, then check the answer
	task automatic run(input row_t x, input logic [5:0] d2);
		@(posedge core_clk);
		{issue_valid, dest1_index, dest2_index} <= {1'h1, 6'h1, d2};
		{qualifying_predicate, operand_form, relation, compare_type, short_immediate, src2_value,
			src2_deferred, src3_value, src3_deferred} <= x[$bits(row_t)-1:5];
		@(posedge core_clk);
		issue_valid <= 1'h0;
		#1;
		`chk(outs, {1'h1, x.e})
	endtask : run
	// reset, table, odd cases
	initial
	begin
		{rst_n, issue_valid, qualifying_predicate, src2_deferred, src3_deferred, operand_form, relation,
			compare_type, short_immediate, src2_value, src3_value, dest1_index, dest2_index} = '0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		#1;
		`chk(outs, 6'h0)
		foreach (rows[i]) run(rows[i], 6'h2);
		run('{1,0,0,0,0,5,0,5,0,5'h10}, 6'h1);
		run('{0,0,0,1,0,5,0,5,0,5'h10}, 6'h1);
		run('{0,0,0,2,0,5,0,5,0,5'h00}, 6'h1);
		run(rows[0], 6'h2);
		@(posedge core_clk);
		#1;
		`chk(preds[2:1], 2'h1)
		// reset in mid-run drops a pending answer
		@(posedge core_clk);
		issue_valid <= 1'h1;
		@(posedge core_clk);
		rst_n <= 1'h0;
		issue_valid <= 1'h0;
		#1;
		`chk(outs, 6'h0)
		`chk(preds, 64'h0)
		repeat (2) @(posedge core_clk);
		rst_n <= 1'h1;
		run(rows[1], 6'h2);
		print_verdict();
	end
	// hang guard
	initial
	begin
		#2000;
		err_count++;
		print_verdict();
	end
endmodule : tb
`default_nettype wire
